// [rtl/plsal_defines.svh]
// Purpose: offsets, field positions, reset values and timing counts for the link setup block
// Assumes: 20 MHz system clock
// Notes: register byte address is four times the index
`ifndef PLSAL_DEFINES_SVH
`define PLSAL_DEFINES_SVH

`define PLSAL_IDX_BMC 6'h00
`define PLSAL_IDX_STAT 6'h01
`define PLSAL_IDX_ADV 6'h04
`define PLSAL_IDX_PHYC 6'h19

`define PLSAL_BMC_RESTART 9
`define PLSAL_BMC_ANEN 12
`define PLSAL_BMC_SPD100 13
`define PLSAL_PHYC_MANX 14
`define PLSAL_PHYC_AUTOX 15

`define PLSAL_BMC_RST 16'h2000
`define PLSAL_PHYC_RST 16'h0000
`define PLSAL_ADV_RST 3'h7

`define PLSAL_CLK_MHZ 20
`define PLSAL_CYC(ns) (((ns) * `PLSAL_CLK_MHZ + 999) / 1000)
`define PLSAL_TX100_NS 105
`define PLSAL_TX10_IN_NS 1350
`define PLSAL_TX10_MS_NS 1300
`define PLSAL_RX100_IN_NS 350
`define PLSAL_RX100_MS_NS 325
`define PLSAL_RX10_NS 2150
`define PLSAL_XOVER_SLOT 5'h14

`endif

// [rtl/plsal_pkg.sv]
// Purpose: shared types of the link setup block
// Assumes: nothing
// Notes: constants live in plsal_defines.svh
package plsal_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_XOVER, ST_NEG, ST_LINK} plsal_link_t;

  typedef struct packed {
    plsal_link_t st;
    logic strapDone;
    logic [15:0] bmc;
    logic [15:0] phyc;
    logic [2:0] adv;
    logic [2:0] partner;
    logic speed100;
    logic mdix;
    logic anDone;
    logic linkUp;
    logic lpiOk;
    logic [4:0] xoverCnt;
    logic flpSend;
    logic txPrev;
    logic [5:0] txCnt;
    logic txGate;
    logic ssd;
    logic [5:0] rxCnt;
    logic crsDv;
    logic mdiVld;
    logic [1:0] mdiDat;
    logic lpiActive;
    logic ampReduced;
    logic awHave;
    logic wHave;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic awReady;
    logic wReady;
    logic bValid;
    logic [1:0] bResp;
    logic arReady;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
  } plsal_state_t;
endpackage

// [rtl/plsal_fifo.sv]
// Purpose: transmit data buffer between MAC side and medium side
// Assumes: depth is a power of two
// Notes: ready and valid are registered so both sides see flop outputs
`timescale 1ns/1ps
module plsal_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
    logic inRdy;
    logic outVld;
  } plsal_fifo_state_t;

  plsal_fifo_state_t state_ff;
  plsal_fifo_state_t nxt_state;
  logic push;
  logic pop;

  assign push = inValid && state_ff.inRdy;
  assign pop = outReady && state_ff.outVld;
  assign inReady = state_ff.inRdy;
  assign outValid = state_ff.outVld;
  assign outData = state_ff.mem[state_ff.rd];

  always_comb begin
    nxt_state = state_ff;
    if (push) begin
      nxt_state.mem[state_ff.wr] = inData;
      nxt_state.wr = state_ff.wr + PW'(1);
    end
    if (pop) begin
      nxt_state.rd = state_ff.rd + PW'(1);
    end
    nxt_state.cnt = state_ff.cnt + CW'(push) - CW'(pop);
    // full and empty taken from the next count keeps them honest without a comb path
    nxt_state.inRdy = (nxt_state.cnt != CW'(DEPTH));
    nxt_state.outVld = (nxt_state.cnt != '0);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '{mem: '0, wr: '0, rd: '0, cnt: '0, inRdy: 1'b1, outVld: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_noOverfill;
    !state_ff.inRdy |-> state_ff.cnt == CW'(DEPTH);
  endproperty
  a_noOverfill: assert property (p_noOverfill) else $error("fifo refuses data while not full");
endmodule // plsal_fifo

// [rtl/plsal_link.sv]
// Purpose: link setup, crossover, negotiation, latency and low power idle control of a PHY
// Assumes: 20 MHz sys_clk; medium side abstracted to pulses and ability words
// Notes: registers over AXI4-Lite, byte address = index * 4
`timescale 1ns/1ps
`include "plsal_defines.svh"
module plsal_link (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // straps and mode
  input wire logic strapAnEn,
  input wire logic strapXoverEn,
  input wire logic clockMaster,
  // medium side link setup
  input wire logic energyDetect,
  input wire logic partnerValid,
  input wire logic [2:0] partnerAbil,
  input wire logic linkLoss,
  output logic flpSend,
  output logic [2:0] flpWord,
  output logic mdix,
  output logic linkUp,
  output logic speed100,
  // mac transmit
  input wire logic txEn,
  input wire logic txValid,
  input wire logic [1:0] txData,
  output logic txReady,
  // medium transmit
  input wire logic mdiReady,
  output logic mdiTxValid,
  output logic [1:0] mdiTxData,
  output logic mdiSsd,
  // receive
  input wire logic rxSsd,
  input wire logic rxActive,
  output logic crsDv,
  // low power idle
  input wire logic macLpiReq,
  output logic lpiActive,
  output logic ampReduced
);
  plsal_pkg::plsal_state_t state_ff;
  plsal_pkg::plsal_state_t nxt;
  logic fifoVld;
  logic [1:0] fifoDat;
  logic fifoPop;
  logic [5:0] txTarget;
  logic [5:0] rxTarget;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic mapped(input logic [5:0] idx);
    mapped = (idx == `PLSAL_IDX_BMC) || (idx == `PLSAL_IDX_STAT) ||
             (idx == `PLSAL_IDX_ADV) || (idx == `PLSAL_IDX_PHYC);
  endfunction

  // tx buffer; mdiReady low stalls the drain and eventually drops txReady
  plsal_fifo #(.WIDTH(2), .DEPTH(8)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inValid(txValid),
    .inData(txData),
    .inReady(txReady),
    .outValid(fifoVld),
    .outData(fifoDat),
    .outReady(fifoPop)
  );

  assign fifoPop = state_ff.txGate && fifoVld && (!state_ff.mdiVld || mdiReady);

  always_comb begin
    if (state_ff.speed100) begin
      txTarget = 6'(`PLSAL_CYC(`PLSAL_TX100_NS));
      rxTarget = clockMaster ? 6'(`PLSAL_CYC(`PLSAL_RX100_MS_NS))
                             : 6'(`PLSAL_CYC(`PLSAL_RX100_IN_NS));
    end else begin
      txTarget = clockMaster ? 6'(`PLSAL_CYC(`PLSAL_TX10_MS_NS))
                             : 6'(`PLSAL_CYC(`PLSAL_TX10_IN_NS));
      rxTarget = 6'(`PLSAL_CYC(`PLSAL_RX10_NS));
    end
  end

  always_comb begin
    nxt = state_ff;
    nxt.flpSend = 1'b0;
    nxt.ssd = 1'b0;
    // straps are caught on the first edge after reset release
    if (!state_ff.strapDone) begin
      nxt.strapDone = 1'b1;
      nxt.bmc[`PLSAL_BMC_ANEN] = strapAnEn;
      nxt.phyc[`PLSAL_PHYC_AUTOX] = strapXoverEn;
    end

    // register write: address and data taken in either order
    if (awvalid && state_ff.awReady) begin
      nxt.awHave = 1'b1;
      nxt.awAddr = awaddr;
      nxt.awReady = 1'b0;
    end
    if (wvalid && state_ff.wReady) begin
      nxt.wHave = 1'b1;
      nxt.wData = wdata;
      nxt.wStrb = wstrb;
      nxt.wReady = 1'b0;
    end
    if (state_ff.awHave && state_ff.wHave && !state_ff.bValid) begin
      nxt.awHave = 1'b0;
      nxt.wHave = 1'b0;
      nxt.bValid = 1'b1;
      nxt.bResp = mapped(state_ff.awAddr[7:2]) ? 2'h0 : 2'h2;
      unique case (state_ff.awAddr[7:2])
        `PLSAL_IDX_BMC: nxt.bmc = merge(state_ff.bmc, state_ff.wData, state_ff.wStrb);
        `PLSAL_IDX_PHYC: nxt.phyc = merge(state_ff.phyc, state_ff.wData, state_ff.wStrb);
        `PLSAL_IDX_ADV: begin
          if (state_ff.wStrb[0]) begin
            nxt.adv = state_ff.wData[2:0];
          end
        end
        default: ;
      endcase
    end
    if (state_ff.bValid && bready) begin
      nxt.bValid = 1'b0;
      nxt.awReady = 1'b1;
      nxt.wReady = 1'b1;
    end

    // register read
    if (arvalid && state_ff.arReady) begin
      nxt.arReady = 1'b0;
      nxt.rValid = 1'b1;
      nxt.rResp = mapped(araddr[7:2]) ? 2'h0 : 2'h2;
      unique case (araddr[7:2])
        `PLSAL_IDX_BMC: nxt.rData = {16'h0000, state_ff.bmc};
        `PLSAL_IDX_PHYC: nxt.rData = {16'h0000, state_ff.phyc};
        `PLSAL_IDX_ADV: nxt.rData = {29'h0, state_ff.adv};
        `PLSAL_IDX_STAT: nxt.rData = {25'h0, state_ff.st, state_ff.lpiOk, state_ff.anDone,
                                      state_ff.mdix, state_ff.speed100, state_ff.linkUp};
        default: nxt.rData = 32'h0000_0000;
      endcase
    end
    if (state_ff.rValid && rready) begin
      nxt.rValid = 1'b0;
      nxt.arReady = 1'b1;
    end

    // link sequence; settings are read only when an attempt starts or leaves crossover or negotiation
    unique case (state_ff.st)
      plsal_pkg::ST_IDLE: begin
        if (state_ff.strapDone) begin
          nxt.xoverCnt = '0;
          if (state_ff.phyc[`PLSAL_PHYC_AUTOX]) begin
            nxt.st = plsal_pkg::ST_XOVER;
          end else begin
            nxt.mdix = state_ff.phyc[`PLSAL_PHYC_MANX];
            if (state_ff.bmc[`PLSAL_BMC_ANEN]) begin
              nxt.st = plsal_pkg::ST_NEG;
              nxt.flpSend = 1'b1;
            end else begin
              nxt.st = plsal_pkg::ST_LINK;
              nxt.speed100 = state_ff.bmc[`PLSAL_BMC_SPD100];
              nxt.linkUp = 1'b1;
            end
          end
        end
      end
      plsal_pkg::ST_XOVER: begin
        // hunt by swapping pairs each slot until the partner's energy shows up
        if (energyDetect) begin
          if (state_ff.bmc[`PLSAL_BMC_ANEN]) begin
            nxt.st = plsal_pkg::ST_NEG;
            nxt.flpSend = 1'b1;
          end else begin
            nxt.st = plsal_pkg::ST_LINK;
            nxt.speed100 = state_ff.bmc[`PLSAL_BMC_SPD100];
            nxt.linkUp = 1'b1;
          end
        end else if (state_ff.xoverCnt == `PLSAL_XOVER_SLOT) begin
          nxt.xoverCnt = '0;
          nxt.mdix = ~state_ff.mdix;
        end else begin
          nxt.xoverCnt = state_ff.xoverCnt + 5'h01;
        end
      end
      plsal_pkg::ST_NEG: begin
        if (partnerValid) begin
          nxt.partner = partnerAbil;
          if (state_ff.adv[1] && partnerAbil[1]) begin
            nxt.speed100 = 1'b1;
            nxt.st = plsal_pkg::ST_LINK;
            nxt.linkUp = 1'b1;
            nxt.anDone = 1'b1;
          end else if (state_ff.adv[0] && partnerAbil[0]) begin
            nxt.speed100 = 1'b0;
            nxt.st = plsal_pkg::ST_LINK;
            nxt.linkUp = 1'b1;
            nxt.anDone = 1'b1;
          end else begin
            nxt.st = plsal_pkg::ST_IDLE;
          end
          nxt.lpiOk = state_ff.adv[2] && partnerAbil[2] &&
                      (state_ff.adv[1:0] & partnerAbil[1:0]) != 2'b00;
        end
      end
      plsal_pkg::ST_LINK: begin
        if (linkLoss) begin
          nxt.st = plsal_pkg::ST_IDLE;
        end
      end
    endcase
    // restart drops the link and starts a fresh attempt
    if (state_ff.bmc[`PLSAL_BMC_RESTART] && state_ff.st != plsal_pkg::ST_IDLE) begin
      nxt.st = plsal_pkg::ST_IDLE;
      nxt.bmc[`PLSAL_BMC_RESTART] = 1'b0;
    end else if (state_ff.bmc[`PLSAL_BMC_RESTART]) begin
      nxt.bmc[`PLSAL_BMC_RESTART] = 1'b0;
    end
    if (nxt.st == plsal_pkg::ST_IDLE) begin
      nxt.linkUp = 1'b0;
      nxt.anDone = 1'b0;
      nxt.lpiOk = 1'b0;
    end

    // transmit latency: count from the edge that sees transmit enable rise
    nxt.txPrev = txEn;
    if (txEn && !state_ff.txPrev && state_ff.linkUp) begin
      nxt.txCnt = txTarget;
    end else if (state_ff.txCnt != 6'h00) begin
      nxt.txCnt = state_ff.txCnt - 6'h01;
      if (state_ff.txCnt == 6'h01) begin
        nxt.ssd = 1'b1;
        nxt.txGate = 1'b1;
      end
    end
    if (state_ff.txGate && !txEn && !fifoVld) begin
      nxt.txGate = 1'b0;
    end
    if (fifoPop) begin
      nxt.mdiVld = 1'b1;
      nxt.mdiDat = fifoDat;
    end else if (mdiReady) begin
      nxt.mdiVld = 1'b0;
    end

    // receive latency: carrier sense follows the delimiter by a fixed count
    if (rxSsd && state_ff.linkUp && state_ff.rxCnt == 6'h00 && !state_ff.crsDv) begin
      nxt.rxCnt = rxTarget;
    end else if (state_ff.rxCnt != 6'h00) begin
      nxt.rxCnt = state_ff.rxCnt - 6'h01;
      if (state_ff.rxCnt == 6'h01) begin
        nxt.crsDv = 1'b1;
      end
    end else if (!rxActive) begin
      nxt.crsDv = 1'b0;
    end

    // low power idle is refused unless both ends agreed on it
    nxt.lpiActive = macLpiReq && nxt.lpiOk;
    nxt.ampReduced = nxt.linkUp && !nxt.speed100;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '{st: plsal_pkg::ST_IDLE, bmc: `PLSAL_BMC_RST, phyc: `PLSAL_PHYC_RST,
                    adv: `PLSAL_ADV_RST, awReady: 1'b1, wReady: 1'b1, arReady: 1'b1,
                    default: '0};
    end else begin
      state_ff <= nxt;
    end
  end

  assign awready = state_ff.awReady;
  assign wready = state_ff.wReady;
  assign bvalid = state_ff.bValid;
  assign bresp = state_ff.bResp;
  assign arready = state_ff.arReady;
  assign rvalid = state_ff.rValid;
  assign rresp = state_ff.rResp;
  assign rdata = state_ff.rData;
  assign flpSend = state_ff.flpSend;
  assign flpWord = state_ff.adv;
  assign mdix = state_ff.mdix;
  assign linkUp = state_ff.linkUp;
  assign speed100 = state_ff.speed100;
  assign mdiTxValid = state_ff.mdiVld;
  assign mdiTxData = state_ff.mdiDat;
  assign mdiSsd = state_ff.ssd;
  assign crsDv = state_ff.crsDv;
  assign lpiActive = state_ff.lpiActive;
  assign ampReduced = state_ff.ampReduced;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_strap;
    $rose(state_ff.strapDone) |-> state_ff.bmc[`PLSAL_BMC_ANEN] == $past(strapAnEn) &&
      state_ff.phyc[`PLSAL_PHYC_AUTOX] == $past(strapXoverEn);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not captured");

  property p_flpAfterXover;
    state_ff.flpSend && $past(state_ff.st) != plsal_pkg::ST_IDLE |->
      $past(state_ff.st) == plsal_pkg::ST_XOVER && $past(energyDetect);
  endproperty
  a_flpAfterXover: assert property (p_flpAfterXover) else $error("burst before crossover");

  property p_resolve;
    $rose(state_ff.anDone) |->
      state_ff.speed100 == (state_ff.adv[1] && state_ff.partner[1]) && state_ff.linkUp;
  endproperty
  a_resolve: assert property (p_resolve) else $error("wrong resolved speed");

  property p_manualX;
    $past(state_ff.st) == plsal_pkg::ST_IDLE && state_ff.st != plsal_pkg::ST_IDLE &&
      !$past(state_ff.phyc[`PLSAL_PHYC_AUTOX]) |-> state_ff.mdix == $past(state_ff.phyc[14]);
  endproperty
  a_manualX: assert property (p_manualX) else $error("manual crossover ignored");

  property p_tx100;
    txEn && !state_ff.txPrev && state_ff.linkUp && state_ff.speed100 |-> !mdiSsd ##4 mdiSsd;
  endproperty
  a_tx100: assert property (p_tx100) else $error("100M delimiter latency wrong");

  property p_tx10;
    txEn && !state_ff.txPrev && state_ff.linkUp && !state_ff.speed100 && clockMaster
      |-> ##27 mdiSsd;
  endproperty
  a_tx10: assert property (p_tx10) else $error("10M master latency wrong");

  property p_rx100;
    rxSsd && state_ff.linkUp && state_ff.speed100 && !clockMaster && state_ff.rxCnt == 6'h00
      && !state_ff.crsDv |-> !crsDv [*8] ##1 crsDv;
  endproperty
  a_rx100: assert property (p_rx100) else $error("100M carrier latency wrong");

  property p_rx10;
    rxSsd && state_ff.linkUp && !state_ff.speed100 && state_ff.rxCnt == 6'h00 &&
      !state_ff.crsDv |-> ##44 crsDv;
  endproperty
  a_rx10: assert property (p_rx10) else $error("10M carrier latency wrong");

  property p_lpi;
    lpiActive |-> state_ff.anDone && state_ff.adv[2] && state_ff.partner[2];
  endproperty
  a_lpi: assert property (p_lpi) else $error("idle without agreement");

  property p_amp;
    state_ff.linkUp |-> ampReduced == !state_ff.speed100;
  endproperty
  a_amp: assert property (p_amp) else $error("10M amplitude not reduced");
endmodule // plsal_link

// [testbench/plsal_partner.sv]
// Purpose: link partner on the cable for the link setup bench
// Assumes: energy is seen only when the pair assignment matches the cable
// Notes: abilities {lpi,100,10}; slow stretches the answer so waits are exercised
`timescale 1ns/1ps
module plsal_partner (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // cable and partner setup
  input wire logic cableX,
  input wire logic slow,
  input wire logic [2:0] abil,
  // device side
  input wire logic flpSend,
  input wire logic mdix,
  output logic energyDetect,
  output logic partnerValid,
  output logic [2:0] partnerAbil
);
  logic busy;
  logic [5:0] waitCnt;

  assign energyDetect = (mdix == cableX);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'h0;
      waitCnt <= 6'h00;
      partnerValid <= 1'h0;
      partnerAbil <= 3'h0;
    end else begin
      partnerValid <= 1'h0;
      // idle word differs from the answer so a stale sample shows up
      partnerAbil <= ~abil;
      if (flpSend) begin
        busy <= 1'h1;
        waitCnt <= slow ? 6'h28 : 6'h02;
      end else if (busy && waitCnt == 6'h00) begin
        busy <= 1'h0;
        partnerValid <= 1'h1;
        partnerAbil <= abil;
      end else if (busy) begin
        waitCnt <= waitCnt - 6'h01;
      end
    end
  end
endmodule // plsal_partner

// [testbench/testbench.sv]
// Purpose: self-checking bench for the link setup block
// Assumes: 20 MHz sys_clk, both straps high, byte address = index * 4
// Notes: latencies counted in edges after the edge that samples the request
`timescale 1ns/1ps
`include "plsal_defines.svh"
module testbench;
  logic sys_clk = 1'h0, rst_n = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic strapAnEn = 1'h1, strapXoverEn = 1'h1, clockMaster = 1'h0;
  logic cableX = 1'h1, slow = 1'h1, linkLoss = 1'h0;
  logic [2:0] abil = 3'h7, partnerAbil, flpWord;
  logic energyDetect, partnerValid, flpSend, mdix, linkUp, speed100;
  logic txEn = 1'h0, txValid = 1'h0, mdiReady = 1'h1, txReady, mdiTxValid, mdiSsd;
  logic [1:0] txData = 2'h0, mdiTxData;
  logic rxSsd = 1'h0, rxActive = 1'h0, macLpiReq = 1'h0, crsDv, lpiActive, ampReduced;
  int error_cnt = 0, num_checks = 0;

  plsal_link uut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready),
    .strapAnEn(strapAnEn), .strapXoverEn(strapXoverEn), .clockMaster(clockMaster),
    .energyDetect(energyDetect), .partnerValid(partnerValid), .partnerAbil(partnerAbil),
    .linkLoss(linkLoss), .flpSend(flpSend), .flpWord(flpWord), .mdix(mdix), .linkUp(linkUp),
    .speed100(speed100), .txEn(txEn), .txValid(txValid), .txData(txData), .txReady(txReady),
    .mdiReady(mdiReady), .mdiTxValid(mdiTxValid), .mdiTxData(mdiTxData), .mdiSsd(mdiSsd),
    .rxSsd(rxSsd), .rxActive(rxActive), .crsDv(crsDv), .macLpiReq(macLpiReq),
    .lpiActive(lpiActive), .ampReduced(ampReduced)
  );
  plsal_partner partner (
    .sys_clk(sys_clk), .rst_n(rst_n), .cableX(cableX), .slow(slow), .abil(abil),
    .flpSend(flpSend), .mdix(mdix), .energyDetect(energyDetect), .partnerValid(partnerValid),
    .partnerAbil(partnerAbil)
  );

  always #25 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [5:0] idx, input logic [15:0] d, output logic [1:0] r);
    logic aw, w;
    @(posedge sys_clk);
    awaddr <= {idx, 2'h0};
    wdata <= {16'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    aw = 1'h0;
    w = 1'h0;
    while (!(aw && w)) begin
      @(negedge sys_clk);
      aw = aw | (awvalid & awready);
      w = w | (wvalid & wready);
      @(posedge sys_clk);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1) @(negedge sys_clk);
    r = bresp;
    @(posedge sys_clk);
    bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (arready !== 1'h1) @(negedge sys_clk);
    @(posedge sys_clk);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1) @(negedge sys_clk);
    d = rdata;
    r = rresp;
    @(posedge sys_clk);
    rready <= 1'h0;
  endtask

  task automatic relink(input logic [15:0] bmc);
    logic [1:0] r;
    axi_wr(`PLSAL_IDX_BMC, bmc | 16'h0200, r);
    for (int i = 0; i < 8 && linkUp !== 1'h0; i++) @(negedge sys_clk);
    for (int i = 0; i < 3000 && linkUp !== 1'h1; i++) @(negedge sys_clk);
    check(linkUp, 1'h1);
  endtask

  // caller stands just after the edge that samples the request
  task automatic lat(input logic rx, input int n);
    int i;
    for (i = 1; i < 100; i++) begin
      @(posedge sys_clk);
      #1;
      if ((rx ? crsDv : mdiSsd) === 1'h1) break;
    end
    check(i, n);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(`PLSAL_IDX_BMC, d, r);
    check(d, 32'h3000);
    axi_rd(`PLSAL_IDX_PHYC, d, r);
    check(d, 32'h8000);
    axi_rd(6'h02, d, r);
    check(d, 32'h0);
    check(r, 2'h2);
    axi_wr(6'h02, 16'hffff, r);
    check(r, 2'h2);
  endtask

  task automatic t_neg();
    logic [31:0] d;
    logic [1:0] r;
    logic [2:0] adv [3] = '{3'h7, 3'h1, 3'h7};
    logic [2:0] pab [3] = '{3'h1, 3'h7, 3'h6};
    logic spd [3] = '{1'h0, 1'h0, 1'h1};
    for (int i = 0; i < 3000 && linkUp !== 1'h1; i++) @(negedge sys_clk);
    check(mdix, 1'h1);
    check(flpWord, 3'h7);
    check(speed100, 1'h1);
    axi_rd(`PLSAL_IDX_STAT, d, r);
    check(d, 32'h7f);
    slow <= 1'h0;
    for (int i = 0; i < 3; i++) begin
      axi_wr(`PLSAL_IDX_ADV, {13'h0, adv[i]}, r);
      abil <= pab[i];
      relink(16'h1000);
      check(speed100, spd[i]);
    end
    axi_wr(`PLSAL_IDX_ADV, 16'h0002, r);
    abil <= 3'h1;
    axi_wr(`PLSAL_IDX_BMC, 16'h1200, r);
    repeat (200) @(negedge sys_clk);
    check(linkUp, 1'h0);
    axi_wr(`PLSAL_IDX_ADV, 16'h0007, r);
    abil <= 3'h7;
  endtask

  task automatic t_force();
    logic [1:0] r;
    cableX <= 1'h0;
    relink(16'h2000);
    check(mdix, 1'h0);
    check(speed100, 1'h1);
    for (int m = 0; m < 2; m++) begin
      axi_wr(`PLSAL_IDX_PHYC, m ? 16'h4000 : 16'h0000, r);
      cableX <= (m == 0);
      relink(16'h2000);
      check(mdix, m[0]);
    end
    axi_wr(`PLSAL_IDX_PHYC, 16'h8000, r);
    cableX <= 1'h1;
  endtask

  task automatic t_tx();
    int n, k;
    logic ok;
    logic [15:0] bm [3] = '{16'h2000, 16'h0000, 16'h0000};
    logic cm [3] = '{1'h0, 1'h0, 1'h1};
    int txN [3] = '{3, 27, 26};
    int rxN [3] = '{7, 43, 43};
    for (int i = 0; i < 3; i++) begin
      relink(bm[i]);
      @(posedge sys_clk);
      clockMaster <= cm[i];
      mdiReady <= 1'h0;
      txValid <= 1'h1;
      txData <= 2'h0;
      n = 0;
      ok = 1'h1;
      // gate is shut while txEn is low, so the buffer only fills
      for (int j = 0; j < 20 && ok; j++) begin
        @(negedge sys_clk);
        ok = (txReady === 1'h1);
        @(posedge sys_clk);
        if (ok) n++;
        txData <= n[1:0];
      end
      txValid <= 1'h0;
      check(n, 8);
      txEn <= 1'h1;
      @(posedge sys_clk);
      lat(1'h0, txN[i]);
      k = 0;
      for (int j = 0; j < 200 && k < 8; j++) begin
        @(posedge sys_clk);
        mdiReady <= j[0];
        @(negedge sys_clk);
        if (mdiTxValid === 1'h1 && mdiReady) begin
          check(mdiTxData, k[1:0]);
          k++;
        end
      end
      check(k, 8);
      @(posedge sys_clk);
      txEn <= 1'h0;
      mdiReady <= 1'h1;
      rxActive <= 1'h1;
      rxSsd <= 1'h1;
      @(posedge sys_clk);
      rxSsd <= 1'h0;
      lat(1'h1, rxN[i]);
      @(posedge sys_clk);
      rxActive <= 1'h0;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      check(crsDv, 1'h0);
    end
  endtask

  task automatic t_lpi();
    logic [2:0] pab [3] = '{3'h7, 3'h5, 3'h3};
    logic el [3] = '{1'h1, 1'h1, 1'h0};
    logic ea [3] = '{1'h0, 1'h1, 1'h0};
    @(posedge sys_clk);
    macLpiReq <= 1'h1;
    repeat (3) @(negedge sys_clk);
    check(lpiActive, 1'h0);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      abil <= pab[i];
      relink(16'h1000);
      repeat (2) @(negedge sys_clk);
      check(lpiActive, el[i]);
      check(ampReduced, ea[i]);
    end
    @(posedge sys_clk);
    macLpiReq <= 1'h0;
    linkLoss <= 1'h1;
    @(posedge sys_clk);
    linkLoss <= 1'h0;
    @(negedge sys_clk);
    check(linkUp, 1'h0);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'h1;
    t_regs();
    t_neg();
    t_force();
    t_tx();
    t_lpi();
    stop_test();
  end

  // whole run is about a thousand cycles; the 60000-cycle limit leaves ample margin
  initial begin
    #3000000;
    error_cnt++;
    stop_test();
  end
endmodule // testbench
